//--- hdl/fxadc_pkg.sv
// Purpose: shared constants and types of the flexible line and converter select block
// Assumes: 100 MHz clock, APB register access with 32-bit data
// Notes: offsets are byte addresses of aligned words
package fxadc_pkg;
   localparam int CLK_NS = 10;
   // =====================================
   // register map
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_TCLK = 8'h04;
   localparam logic [7:0] ADDR_ADC = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   localparam logic [7:0] ADDR_RES = 8'h10;
   localparam logic [7:0] ADDR_DIO = 8'h14;
   localparam logic [7:0] ADDR_DIN = 8'h18;
   localparam logic [7:0] ADDR_ID = 8'h1C;
   // =====================================
   // field positions
   localparam int CFG_GA_LSB = 8;
   localparam int CFG_EA_LSB = 16;
   localparam int CFG_WS_LSB = 24;
   localparam int WS_TC = 0;
   localparam int WS_GA = 2;
   localparam int WS_EA = 3;
   localparam int TC_CNT0 = 2;
   localparam int TC_CNT1 = 3;
   localparam int TC_BASE_LSB = 4;
   localparam int TCLK_DIV_LSB = 8;
   localparam int ADC_NEG_LSB = 5;
   localparam int ADC_FAST = 10;
   localparam int ADC_SETTLE = 11;
   localparam int ADC_GO = 12;
   // =====================================
   // reset values and codes
   localparam logic [3:0] WS_RST = 4'hF;
   localparam logic [7:0] TC_RST = 8'h40;
   localparam logic [7:0] GA_RST = 8'h00;
   localparam logic [7:0] EA_RST = 8'h00;
   localparam logic [7:0] TCLK_SEL_RST = 8'h82;
   localparam logic [7:0] TCLK_DIV_RST = 8'h00;
   localparam logic [1:0] MAX_TIMERS = 2'h2;
   localparam logic [4:0] CH_TEMP = 5'h1E;
   localparam logic [4:0] CH_VREG = 5'h1F;
   localparam logic [4:0] NEG_VREF = 5'h1E;
   localparam logic [4:0] NEG_SE = 5'h1F;
   localparam logic [7:0] EP_CMD = 8'h01;
   localparam logic [7:0] EP_STREAM = 8'h82;
   localparam logic [15:0] RESP_OK = 16'h0000;
   localparam logic [15:0] RESP_BADCH = 16'h0001;
   localparam logic [15:0] RESP_BUSY = 16'h0002;
   // =====================================
   // timing
   localparam int EXT_SETTLE_NS = 20000;
   localparam int SETTLE_CYC = (EXT_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLINK_HALF_NS = 100000000;
   localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_NS;
   localparam int LED_TOGGLES = 8;
   // =====================================
   // types
   typedef enum logic [1:0] {FN_DIN, FN_DOUT, FN_ANALOG, FN_TC} fxadc_func_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONV} fxadc_state_t;
   typedef struct packed {
      logic [4:0] pos;
      logic [4:0] neg;
      logic fast;
      logic settle;
   } fxadc_sel_t;
   typedef struct packed {
      logic valid;
      logic [7:0] ep;
      logic [15:0] data;
   } fxadc_msg_t;
endpackage

//--- hdl/fxadc_channel_select.sv
// Purpose: flexible line configuration and converter channel select with APB registers
// Assumes: converter and pad logic run on clk; line inputs are asynchronous
// Notes: response and sample messages are one-cycle pulses tagged with endpoint
// Notes on behaviour
// [R1] commands arrive on endpoint 0x01; their responses go back on 0x01
// [R2] endpoint 0x82 carries only streamed samples, never command responses
// [R3] host never sends on dummy endpoint 0x03; only 0x83 IN is used
// [R4] vendor and product identifiers are reported to the host
// [R5] green status light blinks after reset, then stays lit
// [R6] each of 16 lines is digital in, digital out or analog
// [R7] at most two timers and two counters at once
// [R8] channels 0-7 are general lines, 8-15 extended lines, fixed
// [R9] timers then counters sit on consecutive lines from the pin base
// [R10] high-voltage variant: first four lines stay analog, digital changes ignored
// [R11] defaults: select 15, no timers or counters, base 4, all digital
// [R12] timer clock select defaults to 130, divisor 0
// [R13] each conversion yields a 12-bit result
// [R14] fast conversion and extended settling options, both off after reset
// [R15] positive 0-15 external, 30 temperature, 31 regulator voltage
// [R16] negative 31 single-ended unipolar, else differential pseudobipolar
// [R17] negative 30 places the reference on the negative input
// [R18] host turns its special code 32 into 30 and adds reference
// [R19] host scales differential readings that involve high-voltage lines
// [R20] results are left-justified in 16-bit words
// [R21] unlisted channel codes are refused with an error response
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/100ps
module fxadc_channel_select #(
   parameter bit HIGH_VOLT = 1'b0,
   parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
   parameter logic [15:0] PRODUCT_ID = 16'h0042, // arbitrary value
   parameter int BLINK_HALF = fxadc_pkg::BLINK_HALF_CYC
) (
   input wire logic clk, // 100 MHz clock
   input wire logic reset, // synchronous, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [15:0] lineIn, // pad input levels
   output logic [15:0] lineOut, // pad output levels
   output logic [15:0] lineOe_n, // pad drive enable, low drives
   output fxadc_pkg::fxadc_func_t [15:0] lineFunc, // per-line function
   output logic [7:0] timerClkSel, // timer clock select
   output logic [7:0] timerClkDiv, // timer clock divide
   output fxadc_pkg::fxadc_sel_t adcSel, // converter mux and options
   output logic adcDiff, // differential conversion
   output logic adcStart, // conversion start pulse
   input wire logic adcDone, // conversion finished
   input wire logic [11:0] adcData, // conversion result
   output fxadc_pkg::fxadc_msg_t sample, // stream sample message
   output fxadc_pkg::fxadc_msg_t resp, // command response message
   output logic led // green status light
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   localparam logic [7:0] HV_MASK = HIGH_VOLT ? 8'h0F : 8'h00;

   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [3:0] ws_r;
   logic [7:0] tc_r;
   logic [7:0] ga_r;
   logic [7:0] ea_r;
   logic [7:0] tclkSel_r;
   logic [7:0] tclkDiv_r;
   logic [15:0] dout_r;
   logic [15:0] dir_r;
   logic [15:0] inMeta_r;
   logic [15:0] inSync_r;
   fxadc_pkg::fxadc_func_t [15:0] lineFunc_r;
   logic [15:0] lineOut_r;
   logic [15:0] lineOe_n_r;
   fxadc_pkg::fxadc_state_t state_r;
   fxadc_pkg::fxadc_sel_t adcSel_r;
   logic adcDiff_r;
   logic adcStart_r;
   logic [15:0] settleCnt_r;
   logic [15:0] result_r;
   logic err_r;
   fxadc_pkg::fxadc_msg_t sample_r;
   fxadc_pkg::fxadc_msg_t resp_r;
   logic led_r;
   logic ledDone_r;
   logic [31:0] ledCnt_r;
   logic [3:0] ledTog_r;

   // =====================================
   // apb slave: no wait states, read data latched in setup
   logic apbSetup;
   logic apbWr;
   logic mapped;
   logic [31:0] rdMux;
   fxadc_pkg::fxadc_sel_t wrSel;
   logic go;

   assign apbSetup = psel && !penable;
   assign apbWr = psel && penable && pready_r && pwrite;
   assign go = apbWr && paddr == fxadc_pkg::ADDR_ADC && pwdata[fxadc_pkg::ADC_GO];
   // register layout differs from the struct order, so pick each field by position
   assign wrSel = {pwdata[4:0], pwdata[fxadc_pkg::ADC_NEG_LSB +: 5], pwdata[fxadc_pkg::ADC_FAST],
      pwdata[fxadc_pkg::ADC_SETTLE]};

   always_comb begin
      mapped = 1'b1;
      rdMux = 32'h0000_0000;
      case (paddr)
         fxadc_pkg::ADDR_CFG: rdMux = {4'h0, ws_r, ea_r, ga_r, tc_r};
         fxadc_pkg::ADDR_TCLK: rdMux = {16'h0000, tclkDiv_r, tclkSel_r};
         fxadc_pkg::ADDR_ADC: rdMux = {20'h0_0000, adcSel_r.settle, adcSel_r.fast, adcSel_r.neg, adcSel_r.pos};
         fxadc_pkg::ADDR_STAT: rdMux = {29'h0000_0000, adcDiff_r, err_r, state_r != fxadc_pkg::ST_IDLE};
         fxadc_pkg::ADDR_RES: rdMux = {16'h0000, result_r};
         fxadc_pkg::ADDR_DIO: rdMux = {dir_r, dout_r};
         fxadc_pkg::ADDR_DIN: rdMux = {16'h0000, inSync_r};
         fxadc_pkg::ADDR_ID: rdMux = {PRODUCT_ID, VENDOR_ID}; // [R4]
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= apbSetup;
         pslverr_r <= apbSetup && !mapped;
         if (apbSetup && !pwrite) begin
            prdata_r <= rdMux;
         end
      end
   end

   // =====================================
   // line configuration, applied per write-select bit
   always_ff @(posedge clk) begin
      if (reset) begin
         ws_r <= fxadc_pkg::WS_RST; // [R11]
         tc_r <= fxadc_pkg::TC_RST; // [R11]
         ga_r <= fxadc_pkg::GA_RST | HV_MASK; // [R11] [R10]
         ea_r <= fxadc_pkg::EA_RST;
      end else if (apbWr && paddr == fxadc_pkg::ADDR_CFG) begin
         ws_r <= pwdata[fxadc_pkg::CFG_WS_LSB +: 4];
         if (pwdata[fxadc_pkg::CFG_WS_LSB + fxadc_pkg::WS_TC]) begin
            tc_r[7:2] <= pwdata[7:2];
            // timer count saturates at two
            tc_r[1:0] <= (pwdata[1:0] > fxadc_pkg::MAX_TIMERS) ? fxadc_pkg::MAX_TIMERS : pwdata[1:0]; // [R7]
         end
         if (pwdata[fxadc_pkg::CFG_WS_LSB + fxadc_pkg::WS_GA]) begin
            ga_r <= pwdata[fxadc_pkg::CFG_GA_LSB +: 8] | HV_MASK; // [R10]
         end
         if (pwdata[fxadc_pkg::CFG_WS_LSB + fxadc_pkg::WS_EA]) begin
            ea_r <= pwdata[fxadc_pkg::CFG_EA_LSB +: 8];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tclkSel_r <= fxadc_pkg::TCLK_SEL_RST; // [R12]
         tclkDiv_r <= fxadc_pkg::TCLK_DIV_RST; // [R12]
      end else if (apbWr && paddr == fxadc_pkg::ADDR_TCLK) begin
         tclkSel_r <= pwdata[7:0];
         tclkDiv_r <= pwdata[fxadc_pkg::TCLK_DIV_LSB +: 8];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dout_r <= 16'h0000;
         dir_r <= 16'h0000;
      end else if (apbWr && paddr == fxadc_pkg::ADDR_DIO) begin
         dout_r <= pwdata[15:0];
         dir_r <= pwdata[31:16];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         inMeta_r <= 16'h0000;
         inSync_r <= 16'h0000;
      end else begin
         inMeta_r <= lineIn;
         inSync_r <= inMeta_r;
      end
   end

   // =====================================
   // per-line function and pad drive
   logic [3:0] tcBase;
   logic [2:0] tcCount;
   logic [15:0] anaSel;

   assign tcBase = tc_r[fxadc_pkg::TC_BASE_LSB +: 4];
   assign tcCount = 3'(tc_r[1:0]) + 3'(tc_r[fxadc_pkg::TC_CNT0]) + 3'(tc_r[fxadc_pkg::TC_CNT1]); // [R7]
   assign anaSel = {ea_r, ga_r}; // [R8]

   for (genvar i = 0; i < 16; i++) begin : g_line
      fxadc_pkg::fxadc_func_t fn;
      logic [4:0] rel;
      assign rel = 5'(i) - {1'b0, tcBase};
      always_comb begin
         if (HIGH_VOLT && i < 4) begin
            fn = fxadc_pkg::FN_ANALOG; // [R10]
         end else if (5'(i) >= {1'b0, tcBase} && rel < {2'b00, tcCount}) begin
            fn = fxadc_pkg::FN_TC; // [R9]
         end else if (anaSel[i]) begin
            fn = fxadc_pkg::FN_ANALOG; // [R6]
         end else if (dir_r[i]) begin
            fn = fxadc_pkg::FN_DOUT; // [R6]
         end else begin
            fn = fxadc_pkg::FN_DIN;
         end
      end
      always_ff @(posedge clk) begin
         if (reset) begin
            lineFunc_r[i] <= (HIGH_VOLT && i < 4) ? fxadc_pkg::FN_ANALOG : fxadc_pkg::FN_DIN; // [R10]
            lineOut_r[i] <= 1'b0;
            lineOe_n_r[i] <= 1'b1;
         end else begin
            lineFunc_r[i] <= fn;
            lineOut_r[i] <= dout_r[i];
            lineOe_n_r[i] <= fn != fxadc_pkg::FN_DOUT;
         end
      end
   end

   // =====================================
   // converter sequencing
   function automatic logic codeOk(input logic [4:0] c);
      codeOk = c < 5'h10 || c == 5'h1E || c == 5'h1F;
   endfunction

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= fxadc_pkg::ST_IDLE;
         adcSel_r <= '0; // [R14]
         adcDiff_r <= 1'b0;
         adcStart_r <= 1'b0;
         settleCnt_r <= 16'h0000;
         result_r <= 16'h0000;
         err_r <= 1'b0;
         sample_r <= '0;
         resp_r <= '0;
      end else begin
         adcStart_r <= 1'b0;
         sample_r.valid <= 1'b0;
         resp_r.valid <= 1'b0;
         if (go) begin
            resp_r.valid <= 1'b1;
            resp_r.ep <= fxadc_pkg::EP_CMD; // [R1]
         end
         case (state_r)
            fxadc_pkg::ST_IDLE: begin
               if (go && !(codeOk(wrSel.pos) && codeOk(wrSel.neg))) begin
                  err_r <= 1'b1; // [R21]
                  resp_r.data <= fxadc_pkg::RESP_BADCH; // [R21]
               end else if (go) begin
                  err_r <= 1'b0;
                  resp_r.data <= fxadc_pkg::RESP_OK;
                  // pos/neg codes drive the mux directly: 0-15 lines, 30/31 internal
                  adcSel_r <= wrSel; // [R15] [R17] [R8]
                  adcDiff_r <= wrSel.neg != fxadc_pkg::NEG_SE; // [R16]
                  if (wrSel.settle) begin
                     settleCnt_r <= 16'(fxadc_pkg::SETTLE_CYC - 1); // [R14]
                     state_r <= fxadc_pkg::ST_SETTLE;
                  end else begin
                     adcStart_r <= 1'b1;
                     state_r <= fxadc_pkg::ST_CONV;
                  end
               end
            end
            fxadc_pkg::ST_SETTLE: begin
               if (go) begin
                  resp_r.data <= fxadc_pkg::RESP_BUSY;
               end
               if (settleCnt_r == 16'h0000) begin
                  adcStart_r <= 1'b1;
                  state_r <= fxadc_pkg::ST_CONV;
               end else begin
                  settleCnt_r <= settleCnt_r - 16'h0001;
               end
            end
            fxadc_pkg::ST_CONV: begin
               if (go) begin
                  resp_r.data <= fxadc_pkg::RESP_BUSY;
               end
               if (adcDone && !adcStart_r) begin
                  result_r <= {adcData, 4'h0}; // [R13] [R20]
                  sample_r.valid <= 1'b1;
                  sample_r.ep <= fxadc_pkg::EP_STREAM; // [R2]
                  sample_r.data <= {adcData, 4'h0}; // [R20]
                  state_r <= fxadc_pkg::ST_IDLE;
               end
            end
            default: state_r <= fxadc_pkg::ST_IDLE;
         endcase
      end
   end

   // =====================================
   // status light: blink after reset, then steady on
   always_ff @(posedge clk) begin
      if (reset) begin
         led_r <= 1'b1;
         ledDone_r <= 1'b0;
         ledCnt_r <= 32'h0000_0000;
         ledTog_r <= 4'h0;
      end else if (ledDone_r) begin
         led_r <= 1'b1; // [R5]
      end else if (ledCnt_r == 32'(BLINK_HALF - 1)) begin
         ledCnt_r <= 32'h0000_0000;
         led_r <= !led_r; // [R5]
         ledTog_r <= ledTog_r + 4'h1;
         ledDone_r <= ledTog_r == 4'(fxadc_pkg::LED_TOGGLES - 1);
      end else begin
         ledCnt_r <= ledCnt_r + 32'h0000_0001;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign lineOut = lineOut_r;
   assign lineOe_n = lineOe_n_r;
   assign lineFunc = lineFunc_r;
   assign timerClkSel = tclkSel_r;
   assign timerClkDiv = tclkDiv_r;
   assign adcSel = adcSel_r;
   assign adcDiff = adcDiff_r;
   assign adcStart = adcStart_r;
   assign sample = sample_r;
   assign resp = resp_r;
   assign led = led_r;

   // =====================================
   // checks
   a_resp_endpoint: assert property (go |=> resp_r.valid && resp_r.ep == 8'h01) // [R1]
      else $error("command response not on endpoint 1");
   a_stream_endpoint: assert property (sample_r.valid |-> sample_r.ep == 8'h82 && !resp_r.valid || go) // [R2]
      else $error("sample not on stream endpoint");
   a_led_steady: assert property (ledDone_r |=> led_r && ledDone_r) // [R5]
      else $error("status light not steady after blinking");
   a_timer_limit: assert property (tc_r[1:0] <= 2'h2) // [R7]
      else $error("more than two timers");
   a_hv_fixed: assert property (HIGH_VOLT |-> lineFunc_r[0] == fxadc_pkg::FN_ANALOG && lineOe_n_r[3:0] == 4'hF) // [R10]
      else $error("high-voltage line left analog mode");
   a_settle_wait: assert property ($rose(state_r == fxadc_pkg::ST_SETTLE) |-> !adcStart_r [*8]) // [R14]
      else $error("conversion started during settling");
   a_single_ended: assert property (adcStart_r |-> adcDiff_r == (adcSel_r.neg != 5'h1F)) // [R16]
      else $error("conversion mode does not follow negative code");
   a_result_justify: assert property (sample_r.valid |-> sample_r.data == {$past(adcData), 4'h0}) // [R20]
      else $error("result not left-justified");
   a_bad_code: assert property (go && state_r == fxadc_pkg::ST_IDLE && wrSel.pos == 5'h10
      |=> resp_r.data == 16'h0001 && err_r && state_r == fxadc_pkg::ST_IDLE) // [R21]
      else $error("bad channel code not refused");
endmodule

//--- tb/fxadc_conv_model.sv
// Purpose: behavioural converter that answers conversion starts from the select block
// Assumes: same clock as the block; result and delay set by the bench
// Notes: between results the data bus toggles so stale values never look valid
`timescale 1ns/100ps
module fxadc_conv_model (
   input wire logic clk, // block clock
   input wire logic reset, // synchronous, active high
   input wire logic adcStart, // start pulse from block
   input wire logic [7:0] delay, // cycles from start to done, at least 1
   input wire logic [11:0] result, // value returned for the next conversion
   output logic adcDone, // one-cycle done pulse
   output logic [11:0] adcData // conversion result
);
   // =====================================
   // conversion timing
   logic busy;
   logic [7:0] cnt;
   always_ff @(posedge clk) begin
      if (reset) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         adcDone <= 1'b0;
         adcData <= 12'h000;
      end else begin
         adcDone <= 1'b0;
         adcData <= ~adcData;
         if (adcStart) begin
            busy <= 1'b1;
            cnt <= delay;
         end else if (busy && cnt <= 8'h01) begin
            busy <= 1'b0;
            adcDone <= 1'b1;
            adcData <= result;
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the flexible line and converter select block
// Assumes: APB master tasks, converter model on the far side
// Notes: a second instance runs as the high-voltage variant on the same bus
`timescale 1ns/100ps
module testbench;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00, cDelay = 8'h03, timerClkSel, timerClkDiv;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, adcStart, adcDone, adcDiff, led, ledQ = 1;
   logic [15:0] lineIn = 16'h0000, lineOut, lineOe_n, hvOe_n;
   logic [11:0] cResult = 12'h5A3, adcData;
   fxadc_pkg::fxadc_func_t [15:0] lineFunc, hvFunc, expF;
   fxadc_pkg::fxadc_sel_t adcSel;
   fxadc_pkg::fxadc_msg_t sample, resp, lastResp, lastSamp;
   int fails = 0, compares = 0, cyc = 0, respCnt = 0, sampCnt = 0, respAt = 0, startAt = 0, ledFlips = 0;
   // neg code 30 is what the host sends in place of its special reference code
   logic [11:0] tab [7] = '{{5'd3, 5'd31, 2'b00}, {5'd15, 5'd30, 2'b10}, {5'd30, 5'd5, 2'b00},
      {5'd31, 5'd31, 2'b01}, {5'd0, 5'd8, 2'b00}, {5'd16, 5'd31, 2'b00}, {5'd7, 5'd29, 2'b00}};

   fxadc_channel_select #(.VENDOR_ID(16'h5A5A), .PRODUCT_ID(16'h0C3C), .BLINK_HALF(4)) i_dut (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lineIn(lineIn),
      .lineOut(lineOut), .lineOe_n(lineOe_n), .lineFunc(lineFunc), .timerClkSel(timerClkSel),
      .timerClkDiv(timerClkDiv), .adcSel(adcSel), .adcDiff(adcDiff), .adcStart(adcStart),
      .adcDone(adcDone), .adcData(adcData), .sample(sample), .resp(resp), .led(led));
   fxadc_channel_select #(.HIGH_VOLT(1'b1), .BLINK_HALF(4)) i_dut_hv (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .lineIn(lineIn), .lineOut(),
      .lineOe_n(hvOe_n), .lineFunc(hvFunc), .timerClkSel(), .timerClkDiv(), .adcSel(), .adcDiff(),
      .adcStart(), .adcDone(adcDone), .adcData(adcData), .sample(), .resp(), .led());
   fxadc_conv_model i_conv (.clk(clk), .reset(reset), .adcStart(adcStart), .delay(cDelay),
      .result(cResult), .adcDone(adcDone), .adcData(adcData));

   always #(fxadc_pkg::CLK_NS / 2) clk = ~clk;

   // =====================================
   // pulse capture and timeout
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ledQ <= led;
      if (!reset && led !== ledQ) ledFlips <= ledFlips + 1;
      if (resp.valid === 1'b1) begin
         lastResp <= resp;
         respCnt <= respCnt + 1;
         respAt <= cyc;
      end
      if (sample.valid === 1'b1) begin
         lastSamp <= sample;
         sampCnt <= sampCnt + 1;
      end
      if (adcStart === 1'b1) startAt <= cyc;
      if (cyc == 20000) begin
         fails = fails + 1;
         finish_test();
      end
   end

   // =====================================
   // shared tasks
   task automatic finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // called just after a rising edge; returns just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdat,
         output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", {31'h0, pready}, 32'h1);
      rdat = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, then one more so registered outputs of the write have settled
      repeat (2) @(posedge clk);
   endtask

   task automatic conv(input logic [11:0] t);
      int r0, s0, k;
      r0 = respCnt;
      s0 = sampCnt;
      k = 0;
      cResult <= cResult + 12'h1B1;
      apb(1'b1, fxadc_pkg::ADDR_ADC, {19'h0, 1'b1, t[0], t[1], t[6:2], t[11:7]}, rd, err);
      chk("respCnt", respCnt - r0, 32'h1);
      if (t[11:7] > 5'd15 && t[11:7] < 5'd30 || t[6:2] > 5'd15 && t[6:2] < 5'd30) begin
         chk("resp", {8'h0, lastResp.ep, lastResp.data}, {8'h0, fxadc_pkg::EP_CMD, fxadc_pkg::RESP_BADCH});
      end else begin
         chk("resp", {8'h0, lastResp.ep, lastResp.data}, {8'h0, fxadc_pkg::EP_CMD, fxadc_pkg::RESP_OK});
         while (sampCnt == s0 && k < 3000) begin
            @(posedge clk);
            k++;
         end
         chk("sample", {8'h0, lastSamp.ep, lastSamp.data}, {8'h0, fxadc_pkg::EP_STREAM, cResult, 4'h0});
         chk("diff", {31'h0, adcDiff}, {31'h0, t[6:2] !== fxadc_pkg::NEG_SE});
         chk("sel", {20'h0, adcSel}, {20'h0, t});
         chk("settle", startAt - respAt, t[0] ? fxadc_pkg::SETTLE_CYC : 0);
      end
   endtask

   // =====================================
   // main sequence
   initial begin
      expF = {16{fxadc_pkg::FN_DIN}};
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      chk("clkSel", {24'h0, timerClkSel}, 32'h0000_0082);
      chk("clkDiv", {24'h0, timerClkDiv}, 32'h0000_0000);
      chk("func", lineFunc, expF);
      chk("oe", {16'h0, lineOe_n}, 32'h0000_FFFF);
      chk("hvFunc", {24'h0, hvFunc[3:0]}, 32'h0000_00AA);
      apb(1'b0, fxadc_pkg::ADDR_CFG, 32'h0, rd, err);
      chk("cfg", rd, 32'h0F00_0040);
      apb(1'b0, fxadc_pkg::ADDR_TCLK, 32'h0, rd, err);
      chk("tclk", rd, 32'h0000_0082);
      apb(1'b0, fxadc_pkg::ADDR_ADC, 32'h0, rd, err);
      chk("adc", rd, 32'h0000_0000);
      apb(1'b0, fxadc_pkg::ADDR_ID, 32'h0, rd, err);
      chk("id", rd, 32'h0C3C_5A5A);
      apb(1'b0, 8'h20, 32'h0, rd, err);
      chk("slverr", {31'h0, err}, 32'h1);
      repeat (40) @(posedge clk);
      chk("ledFlips", ledFlips, fxadc_pkg::LED_TOGGLES);
      chk("led", {31'h0, led}, 32'h1);
      apb(1'b1, fxadc_pkg::ADDR_CFG, 32'h0D01_0447, rd, err);
      expF[2] = fxadc_pkg::FN_ANALOG;
      expF[8] = fxadc_pkg::FN_ANALOG;
      for (int i = 4; i < 7; i++) expF[i] = fxadc_pkg::FN_TC;
      chk("func", lineFunc, expF);
      apb(1'b1, fxadc_pkg::ADDR_DIO, 32'h028F_0201, rd, err);
      for (int i = 0; i < 10; i++) if (i < 2 || i == 3 || i == 7 || i == 9) expF[i] = fxadc_pkg::FN_DOUT;
      chk("func", lineFunc, expF);
      chk("out", {16'h0, lineOut}, 32'h0000_0201);
      chk("oe", {16'h0, lineOe_n}, 32'h0000_FD74);
      chk("hvFunc", {24'h0, hvFunc[3:0]}, 32'h0000_00AA);
      chk("hvOe", {28'h0, hvOe_n[3:0]}, 32'h0000_000F);
      apb(1'b1, fxadc_pkg::ADDR_CFG, 32'h00FF_FF81, rd, err);
      chk("func", lineFunc, expF);
      apb(1'b1, fxadc_pkg::ADDR_CFG, 32'h0100_0081, rd, err);
      for (int i = 4; i < 7; i++) expF[i] = fxadc_pkg::FN_DIN;
      expF[8] = fxadc_pkg::FN_TC;
      chk("func", lineFunc, expF);
      lineIn <= 16'hA55A;
      repeat (3) @(posedge clk);
      apb(1'b0, fxadc_pkg::ADDR_DIN, 32'h0, rd, err);
      chk("din", {16'h0, rd[15:0]}, 32'h0000_A55A);
      for (int i = 0; i < 7; i++) conv(tab[i]);
      cDelay <= 8'd40;
      apb(1'b1, fxadc_pkg::ADDR_ADC, 32'h0000_13E3, rd, err);
      apb(1'b1, fxadc_pkg::ADDR_ADC, 32'h0000_13E3, rd, err);
      chk("busy", {16'h0, lastResp.data}, {16'h0, fxadc_pkg::RESP_BUSY});
      repeat (60) @(posedge clk);
      chk("sample", {8'h0, lastSamp.ep, lastSamp.data}, {8'h0, fxadc_pkg::EP_STREAM, cResult, 4'h0});
      finish_test();
   end
endmodule
